/* rtl/vfp_consts.svh */
/*
 * Scale factors, hysteresis figures and setting codes for the
 * voltage and frequency protection block.
 * Assumes voltages in 0.01 V units and frequency in 0.01 Hz units.
 */
`ifndef VFP_CONSTS_SVH
`define VFP_CONSTS_SVH

// =====================================================================
// Measurement scaling
// =====================================================================
// Centivolts per volt of setting
`define VFP_CV_PER_V       24'h00_0064
// Frequency counts (0.01 Hz) per setting step (0.1 Hz)
`define VFP_FREQ_PER_STEP  24'h00_000A
// Phase A level below which frequency elements are inhibited, volts
`define VFP_FREQ_MIN_V     24'h00_000A

// =====================================================================
// Hysteresis
// =====================================================================
// High-voltage drop-out, percent of threshold
`define VFP_HV_CLR_PCT     24'h00_0062
// Low-voltage drop-out, percent of threshold
`define VFP_LV_CLR_PCT     24'h00_0066
// Imbalance drop-out margin, percent
`define VFP_IMB_HYST_PCT   6'h01

// =====================================================================
// Setting codes
// =====================================================================
// Threshold code meaning disabled
`define VFP_THR_DISABLED   0

`endif

/* rtl/vfp_pkg.sv */
/*
 * Types for the voltage and frequency protection block.
 * Assumes nothing of its surroundings.
 */
package vfp_pkg;

    // =================================================================
    // Stage sequencing
    // =================================================================
    typedef enum logic [1:0] {
        VFP_IDLE    = 2'b00,
        VFP_PICKUP  = 2'b01,
        VFP_TRIPPED = 2'b10
    } vfp_state_t;

    // =================================================================
    // Comparator direction
    // =================================================================
    typedef enum logic {
        VFP_DIR_LOW  = 1'b0,
        VFP_DIR_HIGH = 1'b1
    } vfp_dir_t;

endpackage

/* rtl/vfp_vcmp.sv */
/*
 * Multi-phase voltage comparator with percentage hysteresis.
 * Assumes voltages in 0.01 V and a threshold in whole volts.
 */
`include "vfp_consts.svh"

module vfp_vcmp #(
    parameter int              N     = 3,
    parameter int              V_W   = 16,
    parameter int              THR_W = 8,
    parameter vfp_pkg::vfp_dir_t DIR = vfp_pkg::VFP_DIR_HIGH
) (
    input  wire logic [N-1:0][V_W-1:0] volt_i,
    input  wire logic [THR_W-1:0]      thr_i,
    output logic                       set_o,
    output logic                       clr_o
);
    import vfp_pkg::*;

    logic [23:0]  pick_lvl;
    logic [23:0]  drop_lvl;
    logic [N-1:0] ph_set;
    logic [N-1:0] ph_clr;

    assign pick_lvl = 24'(thr_i) * `VFP_CV_PER_V;
    assign drop_lvl = 24'(thr_i) *
                      ((DIR == VFP_DIR_HIGH) ? `VFP_HV_CLR_PCT : `VFP_LV_CLR_PCT);

    // =================================================================
    // Per-phase compare, shared threshold
    // =================================================================
    for (genvar p = 0; p < N; p++) begin : g_ph
        if (DIR == VFP_DIR_HIGH) begin : g_hi
            assign ph_set[p] = 24'(volt_i[p]) > pick_lvl;
            assign ph_clr[p] = 24'(volt_i[p]) < drop_lvl;
        end else begin : g_lo
            assign ph_set[p] = 24'(volt_i[p]) < pick_lvl;
            assign ph_clr[p] = 24'(volt_i[p]) > drop_lvl;
        end
    end

    // Any phase picks up; all phases must recover to drop out
    assign set_o = |ph_set;
    assign clr_o = &ph_clr;

endmodule

/* rtl/vfp_stage.sv */
/*
 * One protection stage: pickup latch, line-cycle delay counter, trip.
 * Assumes set and clear conditions synchronous to sys_clk_i and a
 * one-cycle line-cycle strobe.
 */
module vfp_stage #(
    parameter int DLY_W = 14
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic             enable_i,
    input  wire logic             strobe_i,
    input  wire logic             set_i,
    input  wire logic             clr_i,
    input  wire logic [DLY_W-1:0] delay_i,
    output logic                  pickup_o,
    output logic                  trip_o
);
    import vfp_pkg::*;

    vfp_state_t       state_r;
    vfp_state_t       state_nxt;
    logic [DLY_W-1:0] cnt_r;
    logic [DLY_W-1:0] cnt_nxt;
    logic [DLY_W-1:0] cnt_inc;
    logic             pickup_r;
    logic             trip_r;

    assign cnt_inc = (&cnt_r) ? cnt_r : cnt_r + 1'b1;

    // =================================================================
    // Sequencing
    // =================================================================
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        if (!enable_i) begin
            state_nxt = VFP_IDLE;
            cnt_nxt   = '0;
        end else begin
            case (state_r)
                VFP_IDLE: begin
                    cnt_nxt = '0;
                    if (set_i) begin
                        state_nxt = (delay_i == '0) ? VFP_TRIPPED : VFP_PICKUP;
                    end
                end
                VFP_PICKUP: begin
                    if (clr_i) begin
                        state_nxt = VFP_IDLE;
                        cnt_nxt   = '0;
                    end else begin
                        if (strobe_i) begin
                            cnt_nxt = cnt_inc;
                        end
                        if (cnt_nxt >= delay_i) begin
                            state_nxt = VFP_TRIPPED;
                        end
                    end
                end
                VFP_TRIPPED: begin
                    if (clr_i) begin
                        state_nxt = VFP_IDLE;
                        cnt_nxt   = '0;
                    end
                end
                default: begin
                    state_nxt = VFP_IDLE;
                    cnt_nxt   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_r <= VFP_IDLE;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pickup_r <= 1'b0;
            trip_r   <= 1'b0;
        end else begin
            pickup_r <= (state_nxt != VFP_IDLE);
            trip_r   <= (state_nxt == VFP_TRIPPED);
        end
    end

    assign pickup_o = pickup_r;
    assign trip_o   = trip_r;

    // =================================================================
    // Checks
    // =================================================================
    chk_disabled_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !enable_i |=> (!pickup_o && !trip_o && cnt_r == '0))
        else $error("disabled stage shows pickup, trip or count");

    chk_trip_has_pickup: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        trip_o |-> pickup_o)
        else $error("trip without pickup");

    chk_zero_delay: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (enable_i && !pickup_o && set_i && delay_i == '0) |=> trip_o)
        else $error("zero delay did not trip at once");

    chk_trip_count: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(trip_o) |-> (cnt_r >= $past(delay_i)))
        else $error("trip before delay count reached");

    chk_clear_both: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (pickup_o && clr_i) |=> (!pickup_o && !trip_o))
        else $error("clear condition did not drop pickup and trip");

    chk_reset_clear: assert property (@(posedge sys_clk_i)
        rst_i |=> (!pickup_o && !trip_o))
        else $error("reset did not clear outputs");

endmodule

/* rtl/vfp_top.sv */
/*
 * Voltage imbalance, high/low voltage and high/low frequency protection.
 * Assumes metering inputs synchronous to sys_clk_i: voltages in 0.01 V,
 * frequency in 0.01 Hz, and a one-cycle strobe per line cycle.
 */
`include "vfp_consts.svh"

module vfp_top #(
    parameter int V_W    = 16,
    parameter int F_W    = 16,
    parameter int VTH_W  = 8,
    parameter int FTH_W  = 10,
    parameter int PCT_W  = 6,
    parameter int DLY_W  = 14
) (
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        cycle_strobe_i,
    input  wire logic                        delta_cfg_i,
    input  wire logic [V_W-1:0]              va_pg_i,
    input  wire logic [V_W-1:0]              vb_pg_i,
    input  wire logic [V_W-1:0]              vc_pg_i,
    input  wire logic [V_W-1:0]              vab_pp_i,
    input  wire logic [V_W-1:0]              vbc_pp_i,
    input  wire logic [V_W-1:0]              vca_pp_i,
    input  wire logic [V_W-1:0]              vaux_i,
    input  wire logic [V_W-1:0]              vpos_seq_i,
    input  wire logic [V_W-1:0]              vneg_seq_i,
    input  wire logic [F_W-1:0]              freq_i,
    input  wire logic [1:0][VTH_W-1:0]       imb_thr_i,
    input  wire logic [1:0][PCT_W-1:0]       imb_pct_i,
    input  wire logic [1:0][DLY_W-1:0]       imb_delay_i,
    input  wire logic [1:0][VTH_W-1:0]       main_hv_thr_i,
    input  wire logic [1:0][DLY_W-1:0]       main_hv_delay_i,
    input  wire logic [1:0][VTH_W-1:0]       main_lv_thr_i,
    input  wire logic [1:0][DLY_W-1:0]       main_lv_delay_i,
    input  wire logic [1:0][VTH_W-1:0]       aux_hv_thr_i,
    input  wire logic [1:0][DLY_W-1:0]       aux_hv_delay_i,
    input  wire logic [1:0][VTH_W-1:0]       aux_lv_thr_i,
    input  wire logic [1:0][DLY_W-1:0]       aux_lv_delay_i,
    input  wire logic [1:0][FTH_W-1:0]       hf_thr_i,
    input  wire logic [1:0][DLY_W-1:0]       hf_delay_i,
    input  wire logic [1:0][FTH_W-1:0]       lf_thr_i,
    input  wire logic [1:0][DLY_W-1:0]       lf_delay_i,
    output logic [1:0]                       voltage_imbalance_pickup_o,
    output logic [1:0]                       voltage_imbalance_trip_o,
    output logic [1:0]                       main_high_voltage_pickup_o,
    output logic [1:0]                       main_high_voltage_trip_o,
    output logic [1:0]                       main_low_voltage_pickup_o,
    output logic [1:0]                       main_low_voltage_trip_o,
    output logic [1:0]                       aux_high_voltage_pickup_o,
    output logic [1:0]                       aux_high_voltage_trip_o,
    output logic [1:0]                       aux_low_voltage_pickup_o,
    output logic [1:0]                       aux_low_voltage_trip_o,
    output logic [1:0]                       high_frequency_pickup_o,
    output logic [1:0]                       high_frequency_trip_o,
    output logic [1:0]                       low_frequency_pickup_o,
    output logic [1:0]                       low_frequency_trip_o
);
    import vfp_pkg::*;

    localparam int NST = 14;
    // Stage slots: 0-1 imbalance, 2-3 main high, 4-5 main low,
    // 6-7 aux high, 8-9 aux low, 10-11 high freq, 12-13 low freq.

    logic [2:0][V_W-1:0]       ph_volt;
    logic                      freq_inhibit;
    logic [NST-1:0]            st_en;
    logic [NST-1:0]            st_set;
    logic [NST-1:0]            st_clr;
    logic [NST-1:0][DLY_W-1:0] st_dly;
    logic [NST-1:0]            st_pu;
    logic [NST-1:0]            st_tr;

    // =================================================================
    // Wye or delta quantity selection
    // =================================================================
    assign ph_volt[0] = delta_cfg_i ? vab_pp_i : va_pg_i;
    assign ph_volt[1] = delta_cfg_i ? vbc_pp_i : vb_pg_i;
    assign ph_volt[2] = delta_cfg_i ? vca_pp_i : vc_pg_i;

    assign freq_inhibit = 24'(ph_volt[0]) < (`VFP_FREQ_MIN_V * `VFP_CV_PER_V);

    // =================================================================
    // Per-stage conditions
    // =================================================================
    for (genvar k = 0; k < 2; k++) begin : g_pair
        logic [23:0]      neg_scaled;
        logic [23:0]      pick_ratio;
        logic [23:0]      drop_ratio;
        logic [23:0]      pos_floor;
        logic [PCT_W-1:0] drop_pct;
        logic [23:0]      hf_lvl;
        logic [23:0]      lf_lvl;

        // Imbalance: V2*100 against pct*V1, no division needed
        assign neg_scaled = 24'(vneg_seq_i) * `VFP_CV_PER_V;
        assign pick_ratio = 24'(imb_pct_i[k]) * 24'(vpos_seq_i);
        assign drop_pct   = (imb_pct_i[k] > `VFP_IMB_HYST_PCT) ?
                            imb_pct_i[k] - `VFP_IMB_HYST_PCT : '0;
        assign drop_ratio = 24'(drop_pct) * 24'(vpos_seq_i);
        assign pos_floor  = 24'(imb_thr_i[k]) * `VFP_CV_PER_V;

        assign st_en[k]  = (imb_thr_i[k] != VTH_W'(`VFP_THR_DISABLED));
        // Pickup also needs V1 at threshold, else it would chatter on the floor
        assign st_set[k] = (neg_scaled > pick_ratio) &&
                           (24'(vpos_seq_i) >= pos_floor);
        assign st_clr[k] = (24'(vpos_seq_i) < pos_floor) ||
                           (neg_scaled < drop_ratio);
        assign st_dly[k] = imb_delay_i[k];

        // Voltage stages
        assign st_en[2+k]  = (main_hv_thr_i[k] != VTH_W'(`VFP_THR_DISABLED));
        assign st_dly[2+k] = main_hv_delay_i[k];
        assign st_en[4+k]  = (main_lv_thr_i[k] != VTH_W'(`VFP_THR_DISABLED));
        assign st_dly[4+k] = main_lv_delay_i[k];
        assign st_en[6+k]  = (aux_hv_thr_i[k] != VTH_W'(`VFP_THR_DISABLED));
        assign st_dly[6+k] = aux_hv_delay_i[k];
        assign st_en[8+k]  = (aux_lv_thr_i[k] != VTH_W'(`VFP_THR_DISABLED));
        assign st_dly[8+k] = aux_lv_delay_i[k];

        vfp_vcmp #(.N(3), .V_W(V_W), .THR_W(VTH_W), .DIR(VFP_DIR_HIGH)) u_main_hv (
            .volt_i (ph_volt),
            .thr_i  (main_hv_thr_i[k]),
            .set_o  (st_set[2+k]),
            .clr_o  (st_clr[2+k])
        );
        vfp_vcmp #(.N(3), .V_W(V_W), .THR_W(VTH_W), .DIR(VFP_DIR_LOW)) u_main_lv (
            .volt_i (ph_volt),
            .thr_i  (main_lv_thr_i[k]),
            .set_o  (st_set[4+k]),
            .clr_o  (st_clr[4+k])
        );
        vfp_vcmp #(.N(1), .V_W(V_W), .THR_W(VTH_W), .DIR(VFP_DIR_HIGH)) u_aux_hv (
            .volt_i (vaux_i),
            .thr_i  (aux_hv_thr_i[k]),
            .set_o  (st_set[6+k]),
            .clr_o  (st_clr[6+k])
        );
        vfp_vcmp #(.N(1), .V_W(V_W), .THR_W(VTH_W), .DIR(VFP_DIR_LOW)) u_aux_lv (
            .volt_i (vaux_i),
            .thr_i  (aux_lv_thr_i[k]),
            .set_o  (st_set[8+k]),
            .clr_o  (st_clr[8+k])
        );

        // Frequency stages, no hysteresis; equal value holds the state
        assign hf_lvl = 24'(hf_thr_i[k]) * `VFP_FREQ_PER_STEP;
        assign lf_lvl = 24'(lf_thr_i[k]) * `VFP_FREQ_PER_STEP;

        assign st_en[10+k]  = (hf_thr_i[k] != FTH_W'(`VFP_THR_DISABLED)) &&
                              !freq_inhibit;
        assign st_set[10+k] = 24'(freq_i) > hf_lvl;
        assign st_clr[10+k] = 24'(freq_i) < hf_lvl;
        assign st_dly[10+k] = hf_delay_i[k];
        assign st_en[12+k]  = (lf_thr_i[k] != FTH_W'(`VFP_THR_DISABLED)) &&
                              !freq_inhibit;
        assign st_set[12+k] = 24'(freq_i) < lf_lvl;
        assign st_clr[12+k] = 24'(freq_i) > lf_lvl;
        assign st_dly[12+k] = lf_delay_i[k];
    end

    // =================================================================
    // Stage array
    // =================================================================
    for (genvar s = 0; s < NST; s++) begin : g_stage
        vfp_stage #(.DLY_W(DLY_W)) u_stage (
            .sys_clk_i (sys_clk_i),
            .rst_i     (rst_i),
            .enable_i  (st_en[s]),
            .strobe_i  (cycle_strobe_i),
            .set_i     (st_set[s]),
            .clr_i     (st_clr[s]),
            .delay_i   (st_dly[s]),
            .pickup_o  (st_pu[s]),
            .trip_o    (st_tr[s])
        );
    end

    // =================================================================
    // Output mapping
    // =================================================================
    assign voltage_imbalance_pickup_o = st_pu[1:0];
    assign voltage_imbalance_trip_o   = st_tr[1:0];
    assign main_high_voltage_pickup_o = st_pu[3:2];
    assign main_high_voltage_trip_o   = st_tr[3:2];
    assign main_low_voltage_pickup_o  = st_pu[5:4];
    assign main_low_voltage_trip_o    = st_tr[5:4];
    assign aux_high_voltage_pickup_o  = st_pu[7:6];
    assign aux_high_voltage_trip_o    = st_tr[7:6];
    assign aux_low_voltage_pickup_o   = st_pu[9:8];
    assign aux_low_voltage_trip_o     = st_tr[9:8];
    assign high_frequency_pickup_o    = st_pu[11:10];
    assign high_frequency_trip_o      = st_tr[11:10];
    assign low_frequency_pickup_o     = st_pu[13:12];
    assign low_frequency_trip_o       = st_tr[13:12];

    // =================================================================
    // Checks
    // =================================================================
    chk_freq_inhibit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        freq_inhibit |=> (st_pu[13:10] == 4'h0 && st_tr[13:10] == 4'h0))
        else $error("frequency stage active with phase A under limit");

    chk_imb_pickup_cause: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(st_pu[0]) |-> $past(st_set[0] && st_en[0]))
        else $error("imbalance pickup without ratio condition");

    chk_hv_hold_band: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (st_pu[2] && st_en[2] && !st_clr[2]) |=> st_pu[2])
        else $error("main high voltage dropped inside hysteresis band");

    chk_lf_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (st_pu[12] && 24'(freq_i) > 24'(lf_thr_i[0]) * `VFP_FREQ_PER_STEP) |=> !st_pu[12])
        else $error("low frequency pickup held above threshold");

endmodule

/* sim/vfp_meter_model.sv */
/*
 * Metering front end model: one-cycle line-cycle strobe.
 * Assumes a free-running system clock and synchronous reset.
 */
module vfp_meter_model #(
    parameter int PERIOD = 8
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    output logic      cycle_strobe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt_r;
    // ================================
    // Line-cycle strobe
    // ================================
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || cnt_r == PERIOD - 1) begin
            cnt_r <= 0;
        end else begin
            cnt_r <= cnt_r + 1;
        end
        cycle_strobe_o <= !rst_i && cnt_r == PERIOD - 1;
    end
endmodule

/* sim/tb.sv */
/*
 * Testbench for the voltage and frequency protection block.
 * Assumes rtl/ on the include path; metering model supplies the strobe.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i, rst_i, cycle_strobe_i, delta_cfg_i;
    logic [15:0] va_pg_i, vb_pg_i, vc_pg_i, vab_pp_i, vbc_pp_i, vca_pp_i, vaux_i;
    logic [15:0] vpos_seq_i, vneg_seq_i, freq_i;
    logic [1:0][7:0] imb_thr_i, main_hv_thr_i, main_lv_thr_i, aux_hv_thr_i, aux_lv_thr_i;
    logic [1:0][5:0] imb_pct_i;
    logic [1:0][9:0] hf_thr_i, lf_thr_i;
    logic [1:0][13:0] imb_delay_i, main_hv_delay_i, main_lv_delay_i, aux_hv_delay_i;
    logic [1:0][13:0] aux_lv_delay_i, hf_delay_i, lf_delay_i;
    logic [1:0] voltage_imbalance_pickup_o, voltage_imbalance_trip_o;
    logic [1:0] main_high_voltage_pickup_o, main_high_voltage_trip_o;
    logic [1:0] main_low_voltage_pickup_o, main_low_voltage_trip_o;
    logic [1:0] aux_high_voltage_pickup_o, aux_high_voltage_trip_o;
    logic [1:0] aux_low_voltage_pickup_o, aux_low_voltage_trip_o;
    logic [1:0] high_frequency_pickup_o, high_frequency_trip_o;
    logic [1:0] low_frequency_pickup_o, low_frequency_trip_o;
    int errors, samples_checked;
    vfp_meter_model meter_u (.sys_clk_i, .rst_i, .cycle_strobe_o(cycle_strobe_i));
    vfp_top dut_u (.sys_clk_i, .rst_i, .cycle_strobe_i, .delta_cfg_i, .va_pg_i, .vb_pg_i,
        .vc_pg_i, .vab_pp_i, .vbc_pp_i, .vca_pp_i, .vaux_i, .vpos_seq_i, .vneg_seq_i, .freq_i,
        .imb_thr_i, .imb_pct_i, .imb_delay_i, .main_hv_thr_i, .main_hv_delay_i, .main_lv_thr_i,
        .main_lv_delay_i, .aux_hv_thr_i, .aux_hv_delay_i, .aux_lv_thr_i, .aux_lv_delay_i,
        .hf_thr_i, .hf_delay_i, .lf_thr_i, .lf_delay_i, .voltage_imbalance_pickup_o,
        .voltage_imbalance_trip_o, .main_high_voltage_pickup_o, .main_high_voltage_trip_o,
        .main_low_voltage_pickup_o, .main_low_voltage_trip_o, .aux_high_voltage_pickup_o,
        .aux_high_voltage_trip_o, .aux_low_voltage_pickup_o, .aux_low_voltage_trip_o,
        .high_frequency_pickup_o, .high_frequency_trip_o, .low_frequency_pickup_o,
        .low_frequency_trip_o);
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // Advance until n strobes have been sampled
    task automatic strobes(int n);
        int k = 0;
        while (k < n) begin
            k += cycle_strobe_i;
            tick(1);
        end
    endtask
    task automatic chk(string nm, logic [1:0] e, logic [1:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic t_hv();
        main_hv_thr_i[0] = 8'h64;
        main_hv_delay_i[0] = 14'h0002;
        vb_pg_i = 16'h2711;
        tick(1);
        chk("mhv_pick", 2'b01, main_high_voltage_pickup_o);
        chk("mhv_trip", 2'b00, main_high_voltage_trip_o);
        strobes(1);
        chk("mhv_trip", 2'b00, main_high_voltage_trip_o);
        strobes(1);
        chk("mhv_trip", 2'b01, main_high_voltage_trip_o);
        vb_pg_i = 16'h2648;
        tick(2);
        chk("mhv_pick", 2'b01, main_high_voltage_pickup_o);
        vb_pg_i = 16'h2647;
        tick(1);
        chk("mhv_trip", 2'b00, main_high_voltage_trip_o | main_high_voltage_pickup_o);
        main_hv_thr_i[0] = '0;
        vb_pg_i = 16'h2328;
    endtask
    task automatic t_lv();
        main_lv_thr_i[1] = 8'h50;
        aux_lv_thr_i[1] = 8'h50;
        {vc_pg_i, vaux_i} = {2{16'h1F3F}};
        tick(1);
        chk("mlv_trip", 2'b10, main_low_voltage_trip_o);
        chk("alv_pick", 2'b10, aux_low_voltage_pickup_o);
        chk("alv_trip", 2'b10, aux_low_voltage_trip_o);
        {vc_pg_i, vaux_i} = {2{16'h1FE0}};
        tick(2);
        chk("mlv_pick", 2'b10, main_low_voltage_pickup_o);
        {vc_pg_i, vaux_i} = {2{16'h1FE1}};
        tick(1);
        chk("lv_all", 2'b00, main_low_voltage_trip_o | aux_low_voltage_pickup_o);
        {main_lv_thr_i, aux_lv_thr_i, vc_pg_i, vaux_i} = {16'h0000, 16'h0000, {2{16'h2328}}};
    endtask
    task automatic t_aux();
        {aux_hv_thr_i[1], aux_hv_delay_i[1], vaux_i} = {8'hC8, 14'h0001, 16'h4E21};
        tick(1);
        chk("ahv_pick", 2'b10, aux_high_voltage_pickup_o);
        chk("ahv_trip", 2'b00, aux_high_voltage_trip_o);
        strobes(1);
        chk("ahv_trip", 2'b10, aux_high_voltage_trip_o);
        vaux_i = 16'h4C90;
        tick(2);
        chk("ahv_trip", 2'b10, aux_high_voltage_trip_o);
        vaux_i = 16'h4C8F;
        tick(1);
        chk("ahv_all", 2'b00, aux_high_voltage_pickup_o | aux_high_voltage_trip_o);
        {aux_hv_thr_i[1], vaux_i} = {8'h00, 16'h2328};
    endtask
    task automatic t_delta();
        {delta_cfg_i, main_hv_thr_i[1], va_pg_i} = {1'b1, 8'h96, 16'h4E20};
        tick(1);
        chk("mhv_pick", 2'b00, main_high_voltage_pickup_o);
        vab_pp_i = 16'h3A99;
        tick(1);
        chk("mhv_pick", 2'b10, main_high_voltage_pickup_o);
        main_hv_thr_i[1] = '0;
        tick(1);
        chk("mhv_pick", 2'b00, main_high_voltage_pickup_o);
        {delta_cfg_i, va_pg_i, vab_pp_i} = {1'b0, {2{16'h2328}}};
    endtask
    task automatic t_freq();
        {hf_thr_i[1], lf_thr_i[0], freq_i, va_pg_i} = {10'h258, 10'h257, 16'h1771, 16'h03E7};
        tick(2);
        chk("hf_pick", 2'b00, high_frequency_pickup_o);
        va_pg_i = 16'h2328;
        tick(1);
        chk("hf_trip", 2'b10, high_frequency_trip_o);
        freq_i = 16'h1770;
        tick(1);
        chk("hf_pick", 2'b10, high_frequency_pickup_o);
        freq_i = 16'h1765;
        tick(1);
        chk("hf_pick", 2'b00, high_frequency_pickup_o);
        chk("lf_trip", 2'b01, low_frequency_trip_o);
        freq_i = 16'h1767;
        tick(1);
        chk("lf_pick", 2'b00, low_frequency_pickup_o);
        {hf_thr_i, lf_thr_i} = '0;
    endtask
    task automatic t_imb();
        {imb_thr_i[0], imb_pct_i[0], imb_delay_i[0]} = {8'h32, 6'h0A, 14'h0001};
        vneg_seq_i = 16'h03E9;
        tick(1);
        chk("imb_pick", 2'b01, voltage_imbalance_pickup_o);
        chk("imb_trip", 2'b00, voltage_imbalance_trip_o);
        strobes(1);
        chk("imb_trip", 2'b01, voltage_imbalance_trip_o);
        vneg_seq_i = 16'h0385;
        tick(1);
        chk("imb_pick", 2'b01, voltage_imbalance_pickup_o);
        vpos_seq_i = 16'h1387;
        tick(1);
        chk("imb_all", 2'b00, voltage_imbalance_pickup_o | voltage_imbalance_trip_o);
        {vpos_seq_i, vneg_seq_i, rst_i} = {16'h2710, 16'h03E9, 1'b1};
        tick(1);
        chk("imb_pick", 2'b00, voltage_imbalance_pickup_o);
        rst_i = 1'b0;
        tick(2);
        chk("imb_pick", 2'b01, voltage_imbalance_pickup_o);
        vneg_seq_i = 16'h0383;
        tick(1);
        chk("imb_pick", 2'b00, voltage_imbalance_pickup_o);
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #20000;
        errors++;
        report_and_stop();
    end
    initial begin
        {rst_i, delta_cfg_i, vneg_seq_i, vpos_seq_i, freq_i} = {2'b10, 16'h0000, 16'h2710, 16'h1770};
        {va_pg_i, vb_pg_i, vc_pg_i, vab_pp_i, vbc_pp_i, vca_pp_i, vaux_i} = {7{16'h2328}};
        {imb_thr_i, imb_pct_i, imb_delay_i, main_hv_thr_i, main_hv_delay_i} = '0;
        {main_lv_thr_i, main_lv_delay_i, aux_hv_thr_i, aux_hv_delay_i} = '0;
        {aux_lv_thr_i, aux_lv_delay_i, hf_thr_i, hf_delay_i, lf_thr_i, lf_delay_i} = '0;
        tick(2);
        rst_i = 1'b0;
        t_hv();
        t_lv();
        t_aux();
        t_delta();
        t_freq();
        t_imb();
        report_and_stop();
    end
endmodule
